/* jkb_pkg.sv */
`default_nettype none
package jkb_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int MS_CYCLES = CLK_MHZ * 1000;
  localparam int DEBOUNCE_MS = 5;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * MS_CYCLES;
  // Control word bit positions
  localparam int CB_MAN_UP = 0;
  localparam int CB_MAN_DN = 1;
  localparam int CB_CONT_EN = 3;
  localparam int CB_POS_REL = 4;
  localparam int CB_JOG_REL = 5;
  localparam int CB_JOG_UP = 8;
  localparam int CB_JOG_DN = 9;
  // Status word bit positions
  localparam int SB_MOVING = 6;
  localparam int SB_POS_ERR = 10;
  // Node address that enables the keys without bus
  localparam logic [6:0] KEY_ADDR = 7'h63;
  // Defaults used when a configuration field is zero, and the percent scale
  localparam logic [15:0] BRK_DELAY_MS = 16'h0096;
  localparam logic [15:0] BRK_CLOSE_MS = 16'h03e8;
  localparam logic [7:0] STALL_PCT = 8'h1e;
  localparam logic [15:0] STALL_MS = 16'h00c8;
  localparam logic [7:0] PCT_SCALE = 8'h64;

  typedef struct packed {
    logic [15:0] step_len;
    logic [15:0] jog_wait_ms;
    logic signed [31:0] upper;
    logic signed [31:0] lower;
    logic [15:0] brk_delay_ms;
    logic [15:0] brk_free_inc;
    logic [15:0] brk_close_ms;
    logic [15:0] fric_idle_ms;
    logic [7:0] stall_pct;
    logic [15:0] stall_ms;
  } jkb_cfg_t;

  typedef struct packed {
    logic inc_pulse;
    logic [15:0] speed;
    logic [15:0] target_speed;
    logic signed [31:0] pos;
  } jkb_fb_t;

  typedef enum logic [1:0] {
    BRK_NONE = 2'b00,
    BRK_HOLD = 2'b01,
    BRK_FRIC = 2'b10
  } jkb_brake_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_BRK_WAIT = 4'h1,
    ST_BRK_FREE = 4'h2,
    ST_STEP = 4'h3,
    ST_JOG_WAIT = 4'h4,
    ST_JOG_RUN = 4'h5,
    ST_MAN_RUN = 4'h6
  } jkb_state_t;

  typedef enum logic [1:0] {
    MD_JOG = 2'b01,
    MD_BUS = 2'b10
  } jkb_mode_t;
endpackage : jkb_pkg
`default_nettype wire

/* jkb_debounce.sv */
`default_nettype none
module jkb_debounce #(
  parameter int CYCLES = 1250000
) (
  // Clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Raw key and clean level
  input wire logic key_raw,
  output logic key_clean
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic s1;
    logic s2;
    logic stable;
    logic [CW-1:0] cnt;
  } jkb_db_st_t;

  jkb_db_st_t st;
  jkb_db_st_t next_st;

  // Two-stage synchroniser, then the level must hold for CYCLES clocks
  always_comb begin
    next_st = st;
    next_st.s1 = key_raw;
    next_st.s2 = st.s1;
    if (st.s2 == st.stable) begin
      next_st.cnt = '0;
    end else if (st.cnt >= LAST) begin
      next_st.stable = st.s2;
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign key_clean = st.stable;
endmodule : jkb_debounce
`default_nettype wire

/* jkb_ms_tick.sv */
`default_nettype none
module jkb_ms_tick #(
  parameter int CYCLES = 250000
) (
  // Clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // One-cycle pulse each millisecond
  output logic tick
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } jkb_tk_st_t;

  jkb_tk_st_t st;
  jkb_tk_st_t next_st;

  // Free-running prescaler
  always_comb begin
    next_st = st;
    next_st.tick = (st.cnt == LAST);
    next_st.cnt = (st.cnt == LAST) ? '0 : st.cnt + CW'(1);
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule : jkb_ms_tick
`default_nettype wire

/* jkb_jog_brake_ctrl.sv */
`default_nettype none
module jkb_jog_brake_ctrl import jkb_pkg::*; #(
  parameter int TICK_CYCLES = MS_CYCLES,
  parameter int DB_CYCLES = DEBOUNCE_CYCLES
) (
  // Clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Bus side
  input wire logic bus_on,
  input wire logic [6:0] node_addr,
  input wire logic [15:0] ctrl_word,
  // Keys
  input wire logic key_up_in,
  input wire logic key_dn_in,
  // Configuration and motor feedback
  input wire jkb_brake_t brake_kind,
  input wire jkb_cfg_t cfg,
  input wire jkb_fb_t fb,
  // Motor and brake
  output logic drive_en,
  output logic drive_dir,
  output logic brake_open,
  output logic fric_tight,
  // Status
  output logic stat_moving,
  output logic stat_pos_err
);
  typedef struct packed {
    jkb_state_t state;
    jkb_mode_t mode;
    logic dir;
    logic run_jog;
    logic up_q;
    logic dn_q;
    logic lock;
    logic brk_open;
    logic fric;
    logic drive_en;
    logic drive_dir;
    logic moving;
    logic pos_err;
    logic [15:0] ms_cnt;
    logic [15:0] inc_cnt;
    logic [15:0] stall_cnt;
    logic [15:0] close_cnt;
  } jkb_st_t;

  jkb_st_t st;
  jkb_st_t next_st;
  logic key_up;
  logic key_dn;
  logic tick;

  // Clean key levels and millisecond tick
  jkb_debounce #(.CYCLES(DB_CYCLES)) u_db_up (
    .clk(clk), .rst(rst), .ce(ce), .key_raw(key_up_in), .key_clean(key_up)
  );
  jkb_debounce #(.CYCLES(DB_CYCLES)) u_db_dn (
    .clk(clk), .rst(rst), .ce(ce), .key_raw(key_dn_in), .key_clean(key_dn)
  );
  jkb_ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk), .rst(rst), .ce(ce), .tick(tick)
  );

  // Release decoding and press sources
  logic keys_en;
  logic bits_en;
  logic press_up;
  logic press_dn;
  logic both;
  logic start_jog;
  logic start_man;
  logic man_up;
  logic man_dn;
  logic cont_en;
  jkb_mode_t cur_mode;
  assign keys_en = bus_on ? (ctrl_word[CB_JOG_REL] && !ctrl_word[CB_POS_REL])
                          : (node_addr == KEY_ADDR);
  assign bits_en = bus_on && !ctrl_word[CB_POS_REL] && !ctrl_word[CB_JOG_REL];
  assign press_up = (keys_en && key_up) || (bits_en && ctrl_word[CB_JOG_UP]);
  assign press_dn = (keys_en && key_dn) || (bits_en && ctrl_word[CB_JOG_DN]);
  assign both = press_up && press_dn;
  assign start_jog = (st.state == ST_IDLE) && !st.lock && !both &&
                     ((press_up && !st.up_q) || (press_dn && !st.dn_q));
  assign man_up = bus_on && ctrl_word[CB_POS_REL] && ctrl_word[CB_MAN_UP];
  assign man_dn = bus_on && ctrl_word[CB_POS_REL] && ctrl_word[CB_MAN_DN];
  assign start_man = (st.state == ST_IDLE) && !start_jog && (man_up != man_dn);
  assign cont_en = !bus_on || ctrl_word[CB_CONT_EN];
  assign cur_mode = (bus_on && ctrl_word[CB_POS_REL]) ? MD_BUS : MD_JOG;

  // Effective configuration with defaults
  logic [15:0] brk_delay;
  logic [15:0] brk_close;
  logic [15:0] stall_ms;
  logic [7:0] stall_pct;
  logic [15:0] pre_wait;
  assign brk_delay = (cfg.brk_delay_ms == 16'h0000) ? BRK_DELAY_MS : cfg.brk_delay_ms;
  assign brk_close = (cfg.brk_close_ms == 16'h0000) ? BRK_CLOSE_MS : cfg.brk_close_ms;
  assign stall_ms = (cfg.stall_ms == 16'h0000) ? STALL_MS : cfg.stall_ms;
  assign stall_pct = (cfg.stall_pct == 8'h00) ? STALL_PCT : cfg.stall_pct;
  assign pre_wait = (brake_kind == BRK_FRIC) ? cfg.fric_idle_ms : brk_delay;

  // Run conditions
  logic held;
  logic man_hold;
  logic at_lim;
  logic slow;
  logic stall_hit;
  logic step_done;
  logic [15:0] inc_nx;
  logic [23:0] spd_x;
  logic [23:0] tgt_x;
  jkb_state_t run_state;
  assign held = st.dir ? press_up : press_dn;
  assign man_hold = st.dir ? (man_up && !man_dn) : (man_dn && !man_up);
  assign at_lim = st.dir ? (fb.pos >= cfg.upper) : (fb.pos <= cfg.lower);
  assign spd_x = 24'(fb.speed) * 24'(PCT_SCALE);
  assign tgt_x = 24'(fb.target_speed) * 24'(stall_pct);
  assign slow = st.drive_en && (spd_x < tgt_x);
  assign stall_hit = slow && tick && (st.stall_cnt >= stall_ms);
  assign inc_nx = st.inc_cnt + 16'h0001;
  assign step_done = fb.inc_pulse && (inc_nx >= cfg.step_len);
  assign run_state = st.run_jog ? ST_STEP : ST_MAN_RUN;

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.up_q = press_up;
    next_st.dn_q = press_dn;
    if (!press_up && !press_dn) begin
      next_st.lock = 1'b0;
    end
    if (slow) begin
      if (tick) begin
        next_st.stall_cnt = st.stall_cnt + 16'h0001;
      end
    end else begin
      next_st.stall_cnt = 16'h0000;
    end
    case (st.state)
      ST_IDLE: begin
        if (st.brk_open && tick) begin
          if (st.close_cnt >= brk_close) begin
            next_st.brk_open = 1'b0;
          end else begin
            next_st.close_cnt = st.close_cnt + 16'h0001;
          end
        end
        if (start_jog || start_man) begin
          next_st.dir = start_jog ? (press_up && !st.up_q) : man_up;
          next_st.run_jog = start_jog;
          next_st.mode = cur_mode;
          next_st.pos_err = 1'b0;
          next_st.ms_cnt = 16'h0000;
          next_st.inc_cnt = 16'h0000;
          next_st.close_cnt = 16'h0000;
          if (brake_kind == BRK_HOLD && !st.brk_open) begin
            next_st.state = ST_BRK_WAIT;
          end else if (brake_kind == BRK_FRIC) begin
            next_st.state = ST_BRK_WAIT;
            next_st.fric = 1'b1;
          end else begin
            next_st.state = start_jog ? ST_STEP : ST_MAN_RUN;
          end
        end
      end
      ST_BRK_WAIT: begin
        if (tick) begin
          if (st.ms_cnt >= pre_wait) begin
            next_st.state = (brake_kind == BRK_HOLD) ? ST_BRK_FREE : run_state;
          end else begin
            next_st.ms_cnt = st.ms_cnt + 16'h0001;
          end
        end
      end
      ST_BRK_FREE: begin
        if (fb.inc_pulse) begin
          if (inc_nx >= cfg.brk_free_inc) begin
            next_st.brk_open = 1'b1;
            next_st.inc_cnt = 16'h0000;
            next_st.state = run_state;
          end else begin
            next_st.inc_cnt = inc_nx;
          end
        end
      end
      ST_STEP: begin
        if (step_done) begin
          next_st.ms_cnt = 16'h0000;
          next_st.state = (held && cont_en) ? ST_JOG_WAIT : ST_IDLE;
        end else if (fb.inc_pulse) begin
          next_st.inc_cnt = inc_nx;
        end
      end
      ST_JOG_WAIT: begin
        if (!held) begin
          next_st.state = ST_IDLE;
        end else if (tick) begin
          if (st.ms_cnt >= cfg.jog_wait_ms) begin
            next_st.state = ST_JOG_RUN;
          end else begin
            next_st.ms_cnt = st.ms_cnt + 16'h0001;
          end
        end
      end
      ST_JOG_RUN: begin
        if (!held || at_lim) begin
          next_st.state = ST_IDLE;
        end
      end
      ST_MAN_RUN: begin
        if (!man_hold || at_lim) begin
          next_st.state = ST_IDLE;
        end
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase
    // Aborts override the sequence
    if (st.state != ST_IDLE) begin
      if (cur_mode != st.mode) begin
        next_st.state = ST_IDLE;
      end
      if (st.run_jog && both) begin
        next_st.state = ST_IDLE;
        next_st.lock = 1'b1;
      end
      if (stall_hit) begin
        next_st.state = ST_IDLE;
        next_st.pos_err = 1'b1;
      end
    end
    if (next_st.state == ST_IDLE) begin
      next_st.fric = 1'b0;
    end
    next_st.drive_en = (next_st.state == ST_BRK_FREE) || (next_st.state == ST_STEP) ||
                       (next_st.state == ST_JOG_RUN) || (next_st.state == ST_MAN_RUN);
    next_st.drive_dir = (next_st.state == ST_BRK_FREE) ? !next_st.dir : next_st.dir;
    next_st.moving = next_st.drive_en;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.mode <= MD_JOG;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign drive_en = st.drive_en;
  assign drive_dir = st.drive_dir;
  assign brake_open = st.brk_open;
  assign fric_tight = st.fric;
  assign stat_moving = st.moving;
  assign stat_pos_err = st.pos_err;

  // Checks
  chk_keys_nobus: assert property (@(posedge clk) disable iff (rst)
    (ce && start_jog && !bus_on) |-> (node_addr == KEY_ADDR) ##1 (st.state != ST_IDLE))
    else $error("jog started without bus at wrong address");
  chk_keys_bus: assert property (@(posedge clk) disable iff (rst)
    (ce && start_jog && bus_on) |-> !ctrl_word[CB_POS_REL] &&
    (ctrl_word[CB_JOG_REL] || ctrl_word[CB_JOG_UP] || ctrl_word[CB_JOG_DN]))
    else $error("jog started without a valid release");
  chk_mode_abort: assert property (@(posedge clk) disable iff (rst)
    (ce && st.state != ST_IDLE && cur_mode != st.mode) |=> (st.state == ST_IDLE && !drive_en))
    else $error("run not aborted on release change");
  chk_step_keeps: assert property (@(posedge clk) disable iff (rst)
    (ce && st.state == ST_STEP && !step_done && !both && cur_mode == st.mode && !stall_hit)
    |=> st.state == ST_STEP)
    else $error("single step left early");
  chk_single_only: assert property (@(posedge clk) disable iff (rst)
    (ce && st.state == ST_STEP && step_done && bus_on && !ctrl_word[CB_CONT_EN])
    |=> st.state == ST_IDLE)
    else $error("continuous run without bit 3");
  chk_wait_len: assert property (@(posedge clk) disable iff (rst)
    (st.state == ST_JOG_WAIT ##1 st.state == ST_JOG_RUN)
    |-> ($past(st.ms_cnt) >= $past(cfg.jog_wait_ms)))
    else $error("continuous run began before wait time");
  chk_both_lock: assert property (@(posedge clk) disable iff (rst)
    (ce && st.state != ST_IDLE && st.run_jog && both) |=> (st.state == ST_IDLE && st.lock))
    else $error("both keys did not abort and lock");
  chk_limit_stop: assert property (@(posedge clk) disable iff (rst)
    (ce && (st.state == ST_JOG_RUN || st.state == ST_MAN_RUN) && at_lim) |=> !drive_en)
    else $error("run passed the limit");
  chk_brake_source: assert property (@(posedge clk) disable iff (rst)
    $rose(st.brk_open) |-> $past(st.state) == ST_BRK_FREE)
    else $error("brake opened outside a run");
  chk_stall_err: assert property (@(posedge clk) disable iff (rst)
    (ce && st.state != ST_IDLE && stall_hit) |=> (stat_pos_err && !stat_moving))
    else $error("stall did not end run with error");
  chk_ce_freeze: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(st))
    else $error("state moved while clock enable low");
endmodule : jkb_jog_brake_ctrl
`default_nettype wire

/* jkb_motor_model.sv */
`default_nettype none
module jkb_motor_model import jkb_pkg::*; (
  // Clocking
  input wire logic clk,
  input wire logic rst,
  // Drive command and forced blockage
  input wire logic drive_en,
  input wire logic drive_dir,
  input wire logic stall,
  // Motor feedback
  output jkb_fb_t fb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic div;
  logic pulse;
  logic signed [31:0] pos;
  logic turning;

  // A blocked shaft never turns, however long it is driven
  assign turning = drive_en && !stall;

  // One increment every second cycle while the shaft turns
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= 1'b0;
      pulse <= 1'b0;
      pos <= 32'sh00000000;
    end else begin
      div <= turning && !div;
      pulse <= turning && div;
      if (turning && div) begin
        pos <= drive_dir ? pos + 32'sd1 : pos - 32'sd1;
      end
    end
  end

  // Speed drops to zero against a fixed target when blocked
  assign fb = '{inc_pulse: pulse, speed: turning ? 16'h0064 : 16'h0000,
                target_speed: 16'h0064, pos: pos};
endmodule : jkb_motor_model
`default_nettype wire

/* test_jkb_jog_brake_ctrl.sv */
`default_nettype none
module test_jkb_jog_brake_ctrl import jkb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic bus_on = 1'b0;
  logic [6:0] node_addr = 7'h63;
  logic [15:0] ctrl_word = 16'h0000;
  logic key_up = 1'b0;
  logic key_dn = 1'b0;
  logic stall = 1'b0;
  jkb_brake_t brake_kind = BRK_NONE;
  jkb_cfg_t cfg = '{step_len: 16'h0003, jog_wait_ms: 16'h0002, upper: 32'sh00100000,
    lower: -32'sh00100000, brk_delay_ms: 16'h0001, brk_free_inc: 16'h0002,
    brk_close_ms: 16'h0002, fric_idle_ms: 16'h0001, stall_pct: 8'h00, stall_ms: 16'h0000};
  jkb_fb_t fb;
  logic drive_en, drive_dir, brake_open, fric_tight, stat_moving, stat_pos_err;
  int bad_count = 0;
  int compares = 0;
  int pulses = 0;

  // Design and motor
  jkb_jog_brake_ctrl #(.TICK_CYCLES(TK), .DB_CYCLES(4)) i_jkb_jog_brake_ctrl (
    .clk(clk), .rst(rst), .ce(ce), .bus_on(bus_on), .node_addr(node_addr),
    .ctrl_word(ctrl_word), .key_up_in(key_up), .key_dn_in(key_dn), .brake_kind(brake_kind),
    .cfg(cfg), .fb(fb), .drive_en(drive_en), .drive_dir(drive_dir), .brake_open(brake_open),
    .fric_tight(fric_tight), .stat_moving(stat_moving), .stat_pos_err(stat_pos_err));
  jkb_motor_model i_jkb_motor_model (.clk(clk), .rst(rst), .drive_en(drive_en),
    .drive_dir(drive_dir), .stall(stall), .fb(fb));

  // Clock and increment counter
  always #2 clk = ~clk;
  always @(posedge clk) if (fb.inc_pulse === 1'b1) pulses++;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  function automatic logic [15:0] bt(input int b);
    return 16'h0001 << b;
  endfunction : bt

  // Waits a bounded time for the drive to reach a level
  task automatic wait_lvl(input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && drive_en !== lvl; i++) tick(1);
    check("drive_en", drive_en, lvl);
  endtask : wait_lvl

  // One whole single step in the given direction
  task automatic step_ok(input logic dir);
    wait_lvl(1'b1, 40);
    check("step dir", drive_dir, dir);
    pulses = 0;
    wait_lvl(1'b0, 40);
    check("step incs", pulses, 3);
  endtask : step_ok

  // Held up key: step, pause, then continuous run
  task automatic jog_cont();
    int gap;
    key_up = 1'b1;
    step_ok(1'b1);
    for (gap = 0; gap < 60 && drive_en !== 1'b1; gap++) tick(1);
    check("jog wait", gap >= 2 * TK && gap <= 4 * TK + 2, 1'b1);
    check("cont dir", {drive_en, drive_dir}, 2'b11);
  endtask : jog_cont

  task automatic print_verdict();
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  // Main sequence
  initial begin
    int i;
    tick(16);
    rst = 1'b0;
    tick(12);
    // No bus, switches at 99: a step completes after early release
    key_up = 1'b1;
    wait_lvl(1'b1, 40);
    key_up = 1'b0;
    pulses = 0;
    wait_lvl(1'b0, 40);
    check("released step incs", pulses, 3);
    tick(30);
    check("after release", drive_en, 1'b0);
    // Other switch value, then bus without release
    node_addr = 7'h62;
    key_up = 1'b1;
    tick(30);
    check("keys at other address", drive_en, 1'b0);
    key_up = 1'b0;
    node_addr = 7'h63;
    bus_on = 1'b1;
    key_dn = 1'b1;
    tick(30);
    check("keys without release", drive_en, 1'b0);
    key_dn = 1'b0;
    tick(12);
    ctrl_word = bt(CB_JOG_REL);
    key_dn = 1'b1;
    step_ok(1'b0);
    tick(40);
    check("single step only", drive_en, 1'b0);
    key_dn = 1'b0;
    tick(12);
    // Continuous run lasts while held; both keys abort and lock
    ctrl_word = bt(CB_JOG_REL) | bt(CB_CONT_EN);
    jog_cont();
    key_up = 1'b0;
    wait_lvl(1'b0, 15);
    tick(12);
    jog_cont();
    key_dn = 1'b1;
    wait_lvl(1'b0, 15);
    key_dn = 1'b0;
    tick(30);
    check("locked until both free", drive_en, 1'b0);
    key_up = 1'b0;
    tick(12);
    // Manual run stops at the upper limit
    cfg.upper = fb.pos + 32'sd10;
    ctrl_word = bt(CB_POS_REL) | bt(CB_MAN_UP);
    wait_lvl(1'b1, 10);
    wait_lvl(1'b0, 60);
    check("stop at limit", fb.pos - cfg.upper <= 1 && fb.pos >= cfg.upper, 1'b1);
    ctrl_word = 16'h0000;
    cfg.upper = 32'sh00100000;
    tick(2);
    ctrl_word = bt(CB_POS_REL) | bt(CB_MAN_UP) | bt(CB_MAN_DN);
    tick(10);
    check("both directions", drive_en, 1'b0);
    ctrl_word = bt(CB_POS_REL) | bt(CB_MAN_DN);
    wait_lvl(1'b1, 10);
    check("down dir", drive_dir, 1'b0);
    ctrl_word = bt(CB_MAN_DN);
    wait_lvl(1'b0, 3);
    ctrl_word = 16'h0000;
    tick(2);
    // Jog bits act as keys only with both releases clear
    ctrl_word = bt(CB_JOG_UP);
    step_ok(1'b1);
    ctrl_word = bt(CB_JOG_DN);
    step_ok(1'b0);
    ctrl_word = bt(CB_JOG_REL);
    tick(2);
    ctrl_word = bt(CB_JOG_REL) | bt(CB_JOG_UP);
    tick(20);
    check("jog bits with release", drive_en, 1'b0);
    ctrl_word = 16'h0000;
    // Blocked shaft: stall abort, error cleared by the next run
    cfg.stall_ms = 16'h0004;
    stall = 1'b1;
    tick(2);
    ctrl_word = bt(CB_POS_REL) | bt(CB_MAN_UP);
    wait_lvl(1'b1, 10);
    check("moving flag", stat_moving, 1'b1);
    tick(3 * TK);
    check("no early stall", drive_en, 1'b1);
    wait_lvl(1'b0, 4 * TK);
    check("stall error", {stat_moving, stat_pos_err}, 2'b01);
    stall = 1'b0;
    ctrl_word = bt(CB_POS_REL) | bt(CB_MAN_DN);
    wait_lvl(1'b1, 10);
    check("error cleared", stat_pos_err, 1'b0);
    ctrl_word = 16'h0000;
    cfg.stall_ms = 16'h0000;
    wait_lvl(1'b0, 3);
    // Holding brake: delay, reverse freeing, late close
    brake_kind = BRK_HOLD;
    tick(2);
    ctrl_word = bt(CB_POS_REL) | bt(CB_MAN_UP);
    tick(3);
    check("brake delay", drive_en, 1'b0);
    wait_lvl(1'b1, 20);
    check("free dir", drive_dir, 1'b0);
    for (i = 0; i < 20 && drive_dir !== 1'b1; i++) tick(1);
    check("run dir", {drive_dir, brake_open}, 2'b11);
    ctrl_word = bt(CB_POS_REL);
    wait_lvl(1'b0, 3);
    check("brake held open", brake_open, 1'b1);
    tick(1);
    ctrl_word = bt(CB_POS_REL) | bt(CB_MAN_UP);
    wait_lvl(1'b1, 3);
    check("no fresh freeing", drive_dir, 1'b1);
    ctrl_word = bt(CB_POS_REL) | bt(CB_CONT_EN);
    wait_lvl(1'b0, 3);
    // Clock enable low freezes the close delay
    ce = 1'b0;
    tick(5 * TK);
    check("frozen brake", brake_open, 1'b1);
    ce = 1'b1;
    tick(5 * TK);
    check("brake closed", brake_open, 1'b0);
    // Friction brake: idle before motion, freed at run end
    brake_kind = BRK_FRIC;
    ctrl_word = bt(CB_POS_REL) | bt(CB_MAN_DN);
    tick(2);
    check("friction idle", {fric_tight, drive_en}, 2'b10);
    wait_lvl(1'b1, 20);
    ctrl_word = bt(CB_POS_REL);
    wait_lvl(1'b0, 3);
    tick(1);
    check("friction freed", fric_tight, 1'b0);
    print_verdict();
  end
endmodule : test_jkb_jog_brake_ctrl
`default_nettype wire
